// File: core/csdf_regs.svh
// constants for the clock select, divide and fanout block
//
// Contract
// - source select high routes differential reference, low routes the test-clock selector
// - test selector passes first test clock when low, second when high
// - each bank divider select high halves the clock, low passes it undivided
// - reset/disable low: all fifteen outputs actively driven with their clock
// - reset/disable high: divider flops held reset, every output high impedance
// - fifteen outputs in four banks of two, three, four and six
// - full and half rate outputs derived from one source, retimed together
// - undriven controls default low; test clocks and inverted reference default high
`ifndef CSDF_REGS_SVH
`define CSDF_REGS_SVH

// bank widths
`define CSDF_BANK_A_W 2
`define CSDF_BANK_B_W 3
`define CSDF_BANK_C_W 4
`define CSDF_BANK_D_W 6
`define CSDF_NUM_BANKS 4

// flat output vector: total width and first bit of each bank
`define CSDF_OUT_W 15
`define CSDF_BANK_A_LO 0
`define CSDF_BANK_B_LO 2
`define CSDF_BANK_C_LO 5
`define CSDF_BANK_D_LO 9

// bit positions in pin_driven_i and in the synchronised pin vector
`define CSDF_PIN_W 11
`define CSDF_PIN_REF_P 0
`define CSDF_PIN_REF_N 1
`define CSDF_PIN_TEST0 2
`define CSDF_PIN_TEST1 3
`define CSDF_PIN_DIV_A 4
`define CSDF_PIN_CHOOSE 8
`define CSDF_PIN_SRC 9
`define CSDF_PIN_RST 10

// level an undriven pin settles to: pull-ups on ref_n and both test clocks
`define CSDF_PIN_DEFAULT 11'h00e

`endif

// File: core/csdf_pkg.sv
// types shared by the clock select, divide and fanout block
package csdf_pkg;
  typedef enum logic [1:0] {
    csdf_src_test0,
    csdf_src_test1,
    csdf_src_diff
  } csdf_src_e;
endpackage

// File: core/csdf_bank.sv
// one output bank: optional halving flop and retimed tri-state outputs
`timescale 1ns/1ps
`include "csdf_regs.svh"
module csdf_bank
  import csdf_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             rise_i,
  input  wire logic             level_i,
  input  wire logic             div_sel_i,
  input  wire logic             disable_i,
  output logic      [WIDTH-1:0] out_o,
  output logic      [WIDTH-1:0] oe_o
);
  logic half;

  // halving flop, held low while disabled so all banks restart in phase
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half <= 1'b0;
    end else if (disable_i) begin
      half <= 1'b0;
    end else if (rise_i) begin
      half <= ~half;
    end
  end

  // both rates leave through the same register stage, keeping edges aligned
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_o <= '0;
      oe_o  <= '0;
    end else if (disable_i) begin
      out_o <= '0;
      oe_o  <= '0;
    end else begin
      out_o <= {WIDTH{div_sel_i ? (rise_i ? ~half : half) : level_i}};
      oe_o  <= '1;
    end
  end
endmodule

// File: core/csdf_top.sv
// clock select, divide and fanout: pin sampling, source select, four banks
`timescale 1ns/1ps
`include "csdf_regs.svh"
module csdf_top
  import csdf_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       diff_ref_clk_p_i,
  input  wire logic                       diff_ref_clk_n_i,
  input  wire logic [1:0]                 test_clk_in_i,
  input  wire logic [3:0]                 bank_div_select_i,
  input  wire logic                       test_clk_choose_i,
  input  wire logic                       diff_ref_choose_i,
  input  wire logic                       reset_out_disable_i,
  input  wire logic [`CSDF_PIN_W-1:0]     pin_driven_i,
  output logic      [`CSDF_BANK_A_W-1:0]  bank_a_out_o,
  output logic      [`CSDF_BANK_A_W-1:0]  bank_a_oe_o,
  output logic      [`CSDF_BANK_B_W-1:0]  bank_b_out_o,
  output logic      [`CSDF_BANK_B_W-1:0]  bank_b_oe_o,
  output logic      [`CSDF_BANK_C_W-1:0]  bank_c_out_o,
  output logic      [`CSDF_BANK_C_W-1:0]  bank_c_oe_o,
  output logic      [`CSDF_BANK_D_W-1:0]  bank_d_out_o,
  output logic      [`CSDF_BANK_D_W-1:0]  bank_d_oe_o
);
  logic                   rst_meta;
  logic                   rst_n;
  logic [`CSDF_PIN_W-1:0] pin_raw;
  logic [`CSDF_PIN_W-1:0] pin_meta;
  logic [`CSDF_PIN_W-1:0] pin_sync;
  logic [`CSDF_PIN_W-1:0] driven_meta;
  logic [`CSDF_PIN_W-1:0] driven_sync;
  logic [`CSDF_PIN_W-1:0] pin;
  logic                   diff_level;
  logic                   next_diff_level;
  logic                   sel_level;
  logic                   sel_prev;
  logic                   sel_rise;
  logic                   out_disable;
  csdf_src_e              src;
  logic [`CSDF_OUT_W-1:0] out_all;
  logic [`CSDF_OUT_W-1:0] oe_all;

  // how the block behaves, edge by edge:
  // - every pin, and the mask that says whether it is wired, is sampled
  //   through two flops; data and mask stay in step, so a pin that is
  //   unplugged mid-run falls to its pull level in the same edge as its data
  // - source select, test selector and receiver feed one level; its rising
  //   edges make a one-cycle pulse shared by all four banks
  // - each bank registers either the level or its halving flop, so a bank
  //   follows a pin change three edges later whatever its rate
  // - a sampled source must run below half this clock or its edges are lost;
  //   that is the price of keeping a single clock
  // - while disabled, outputs and output enables read zero and halving flops
  //   sit low, so releasing the disable restarts every halved bank in phase

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gather the pins; every one comes from outside the clock domain
  assign pin_raw = {reset_out_disable_i, diff_ref_choose_i, test_clk_choose_i, bank_div_select_i,
                    test_clk_in_i, diff_ref_clk_n_i, diff_ref_clk_p_i};

  // two-flop synchroniser; the first stage feeds only the second
  // the wired mask takes the same two stages so it never runs ahead of the data
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta    <= `CSDF_PIN_DEFAULT;
      pin_sync    <= `CSDF_PIN_DEFAULT;
      driven_meta <= '0;
      driven_sync <= '0;
    end else begin
      pin_meta    <= pin_raw;
      pin_sync    <= pin_meta;
      driven_meta <= pin_driven_i;
      driven_sync <= driven_meta;
    end
  end

  // an unconnected pin reads as its pull level
  assign pin = (pin_sync & driven_sync) | (`CSDF_PIN_DEFAULT & ~driven_sync);

  ////////////////////////////////////////////////////////////////////////////
  // differential receiver: a common-mode input (both legs equal) holds the last level
  assign next_diff_level = (pin[`CSDF_PIN_REF_P] != pin[`CSDF_PIN_REF_N]) ? pin[`CSDF_PIN_REF_P] : diff_level;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      diff_level <= 1'b0;
    end else begin
      diff_level <= next_diff_level;
    end
  end

  // source decode: the reference path overrides the test selector
  always_comb begin
    if (pin[`CSDF_PIN_SRC]) begin
      src = csdf_src_diff;
    end else if (pin[`CSDF_PIN_CHOOSE]) begin
      src = csdf_src_test1;
    end else begin
      src = csdf_src_test0;
    end
  end

  always_comb begin
    unique case (src)
      csdf_src_test0: begin
        sel_level = pin[`CSDF_PIN_TEST0];
      end
      csdf_src_test1: begin
        sel_level = pin[`CSDF_PIN_TEST1];
      end
      csdf_src_diff: begin
        sel_level = next_diff_level;
      end
      default: begin
        sel_level = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // one edge detector shared by all banks, so every rate follows the same source
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev <= 1'b0;
    end else begin
      sel_prev <= sel_level;
    end
  end

  assign sel_rise    = sel_level & ~sel_prev;
  assign out_disable = pin[`CSDF_PIN_RST];

  ////////////////////////////////////////////////////////////////////////////
  // bank geometry: width of each bank in the flat output vectors
  function automatic int bank_width(input int idx);
    int w;
    w = 0;
    case (idx)
      0: begin
        w = `CSDF_BANK_A_W;
      end
      1: begin
        w = `CSDF_BANK_B_W;
      end
      2: begin
        w = `CSDF_BANK_C_W;
      end
      3: begin
        w = `CSDF_BANK_D_W;
      end
      default: begin
        w = 0;
      end
    endcase
    return w;
  endfunction

  // bank geometry: first bit of each bank in the flat output vectors
  function automatic int bank_base(input int idx);
    int lo;
    lo = 0;
    case (idx)
      0: begin
        lo = `CSDF_BANK_A_LO;
      end
      1: begin
        lo = `CSDF_BANK_B_LO;
      end
      2: begin
        lo = `CSDF_BANK_C_LO;
      end
      3: begin
        lo = `CSDF_BANK_D_LO;
      end
      default: begin
        lo = 0;
      end
    endcase
    return lo;
  endfunction

  // divide select of one bank; one pin per bank, bank A lowest
  function automatic logic bank_halve(input logic [`CSDF_PIN_W-1:0] p, input int idx);
    return p[`CSDF_PIN_DIV_A + idx];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // four banks of two, three, four and six outputs, end to end in one vector;
  // all see the same rise pulse and level, so a 1X bank and a halved bank
  // change in the same register stage
  for (genvar b = 0; b < `CSDF_NUM_BANKS; b++) begin : g_bank
    csdf_bank #(.WIDTH(bank_width(b))) u_bank (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n),
      .rise_i    (sel_rise),
      .level_i   (sel_level),
      .div_sel_i (bank_halve(pin, b)),
      .disable_i (out_disable),
      .out_o     (out_all[bank_base(b) +: bank_width(b)]),
      .oe_o      (oe_all[bank_base(b) +: bank_width(b)])
    );
  end

  // fan the flat vectors back out to the bank ports
  assign bank_a_out_o = out_all[`CSDF_BANK_A_LO +: `CSDF_BANK_A_W];
  assign bank_a_oe_o  = oe_all[`CSDF_BANK_A_LO +: `CSDF_BANK_A_W];
  assign bank_b_out_o = out_all[`CSDF_BANK_B_LO +: `CSDF_BANK_B_W];
  assign bank_b_oe_o  = oe_all[`CSDF_BANK_B_LO +: `CSDF_BANK_B_W];
  assign bank_c_out_o = out_all[`CSDF_BANK_C_LO +: `CSDF_BANK_C_W];
  assign bank_c_oe_o  = oe_all[`CSDF_BANK_C_LO +: `CSDF_BANK_C_W];
  assign bank_d_out_o = out_all[`CSDF_BANK_D_LO +: `CSDF_BANK_D_W];
  assign bank_d_oe_o  = oe_all[`CSDF_BANK_D_LO +: `CSDF_BANK_D_W];
endmodule

// File: verif/csdf_top_assertions.sv
// assertion checker on the ports of the clock fanout top
`timescale 1ns/1ps
`include "csdf_regs.svh"
module csdf_top_assertions
  import csdf_pkg::*;
(
  input wire logic        clock_i, arst_n_i, diff_ref_clk_p_i, diff_ref_clk_n_i,
  input wire logic [1:0]  test_clk_in_i,
  input wire logic [3:0]  bank_div_select_i,
  input wire logic        test_clk_choose_i, diff_ref_choose_i, reset_out_disable_i,
  input wire logic [10:0] pin_driven_i,
  input wire logic [1:0]  bank_a_out_o, bank_a_oe_o,
  input wire logic [2:0]  bank_b_out_o, bank_b_oe_o,
  input wire logic [3:0]  bank_c_out_o, bank_c_oe_o,
  input wire logic [5:0]  bank_d_out_o, bank_d_oe_o
);
  // pin levels after pull substitution and the selected source level
  wire [10:0] pv = (pin_driven_i & {reset_out_disable_i, diff_ref_choose_i, test_clk_choose_i, bank_div_select_i,
    test_clk_in_i, diff_ref_clk_n_i, diff_ref_clk_p_i}) | (~pin_driven_i & `CSDF_PIN_DEFAULT);
  wire        lv   = pv[9] ? pv[0] : pv[8] ? pv[3] : pv[2];
  wire [14:0] oe   = {bank_d_oe_o, bank_c_oe_o, bank_b_oe_o, bank_a_oe_o};
  wire [14:0] outs = {bank_d_out_o, bank_c_out_o, bank_b_out_o, bank_a_out_o};
  logic [34:0] chs;
  logic [4:0]  lhs;
  logic [3:0]  rc;
  // calm: controls unchanged for five samples, longer than the three-edge output lag
  wire calm = rc == 4'hf && chs == {5{pv[10:4]}};
  // cycles since reset release, saturating
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc <= 4'h0;
    end else if (rc != 4'hf) begin
      rc <= rc + 4'h1;
    end
  end
  // history needs no reset since calm waits on the counter
  always_ff @(posedge clock_i) begin
    chs <= {chs[27:0], pv[10:4]};
    lhs <= {lhs[3:0], lv};
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_on;
    calm && !pv[10];
  endsequence
  sequence s_half;
    s_on ##0 pv[7] && !pv[4];
  endsequence
  a_off_float: assert property (calm && pv[10] |-> oe == 15'h0000 && outs == 15'h0000)
    else $error("outputs not floated while disabled");
  a_on_drive: assert property (s_on |-> oe == 15'h7fff)
    else $error("outputs not driven while enabled");
  a_bank_same: assert property (outs == {{6{outs[9]}}, {4{outs[5]}}, {3{outs[2]}}, {2{outs[0]}}})
    else $error("bank bits differ");
  // an undivided bank shows the level seen three samples back, held in lhs[2]
  a_diff_path: assert property (s_on ##0 pv[9] && !pv[4] && pin_driven_i[1:0] == 2'h3
    |-> bank_a_out_o == {2{lhs[2]}})
    else $error("reference level not routed");
  a_test_path: assert property (s_on ##0 !pv[9] && !pv[4] |-> bank_a_out_o[0] == lhs[2])
    else $error("test clock level not routed");
  a_half_tog: assert property (s_half ##0 $rose(bank_a_out_o[0]) |-> bank_d_out_o[0] != $past(bank_d_out_o[0]))
    else $error("halved bank missed a toggle");
  a_rise_only: assert property (s_half ##0 bank_d_out_o[0] != $past(bank_d_out_o[0]) |-> $rose(bank_a_out_o[0]))
    else $error("halved bank toggled off a rising edge");
  a_undiv_same: assert property (s_on ##0 !pv[4] && !pv[5] |-> bank_b_out_o[0] == bank_a_out_o[0])
    else $error("undivided banks out of step");
endmodule

// File: verif/csdf_src_model.sv
// clock sources on the far side: complementary reference legs and two test clocks
`timescale 1ns/1ps
module csdf_src_model (
  input  wire logic  clock_i,
  output logic       ref_p_o,
  output logic       ref_n_o,
  output logic [1:0] test_o
);
  logic [7:0] cnt = 8'h00;
  logic       rp  = 1'b0;
  logic [1:0] tc  = 2'b00;
  // legs stay complementary, so the held-level case never arises on driven legs
  assign ref_p_o = rp;
  assign ref_n_o = ~rp;
  assign test_o  = tc;
  // slow square waves with unlike periods so their phases drift apart
  always @(posedge clock_i) begin
    cnt   <= cnt + 8'h01;
    rp    <= (cnt % 8'h05 == 8'h00) ? ~rp : rp;
    tc[0] <= (cnt % 8'h07 == 8'h00) ? ~tc[0] : tc[0];
    tc[1] <= (cnt % 8'h04 == 8'h00) ? ~tc[1] : tc[1];
  end
endmodule

// File: verif/csdf_top_tb.sv
// self-checking bench for the clock fanout top
`timescale 1ns/1ps
`include "csdf_regs.svh"
module csdf_top_tb;
  import csdf_pkg::*;
  logic        clock_i = 1'b0, arst_n_i = 1'b0, rst = 1'b1, ch = 1'b0, src = 1'b0, go = 1'b0;
  logic        hd = 1'b0, lp = 1'b0;
  logic [3:0]  dv = 4'h0, ds = 4'h0;
  logic [10:0] drv = 11'h7ff;
  logic [31:0] seed = 32'h0000_0025; // xorshift start value, 37
  logic [29:0] q [$];
  wire         p, n;
  wire [1:0]   t;
  wire [29:0]  got;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  csdf_src_model csdf_src_model_inst (.clock_i(clock_i), .ref_p_o(p), .ref_n_o(n), .test_o(t));
  csdf_top csdf_top_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .diff_ref_clk_p_i(p), .diff_ref_clk_n_i(n),
    .test_clk_in_i(t), .bank_div_select_i(dv), .test_clk_choose_i(ch), .diff_ref_choose_i(src),
    .reset_out_disable_i(rst), .pin_driven_i(drv), .bank_a_out_o(got[1:0]), .bank_a_oe_o(got[16:15]),
    .bank_b_out_o(got[4:2]), .bank_b_oe_o(got[19:17]), .bank_c_out_o(got[8:5]), .bank_c_oe_o(got[23:20]),
    .bank_d_out_o(got[14:9]), .bank_d_oe_o(got[29:24]));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input logic [29:0] e, input logic [29:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial forever #4 clock_i = ~clock_i;
  // reference: each pin sample predicts the outputs two edges later
  always @(posedge clock_i) begin : ref_model
    logic [10:0] pv;
    logic [14:0] o;
    logic [3:0]  nd;
    logic        dl, lv;
    pv = (drv & {rst, src, ch, dv, t, n, p}) | (~drv & `CSDF_PIN_DEFAULT);
    dl = (pv[0] !== pv[1]) ? pv[0] : hd;
    lv = pv[9] ? dl : pv[8] ? pv[3] : pv[2];
    nd = pv[10] ? 4'h0 : ds ^ {4{lv & ~lp}};
    o  = {{6{pv[7] ? nd[3] : lv}}, {4{pv[6] ? nd[2] : lv}}, {3{pv[5] ? nd[1] : lv}}, {2{pv[4] ? nd[0] : lv}}};
    hd <= dl;
    lp <= lv;
    ds <= nd;
    if (go) q.push_back({{15{~pv[10]}}, pv[10] ? 15'h0000 : o});
  end
  // watcher: the oldest note meets the outputs once the lag has passed
  always @(negedge clock_i) begin
    if (go && q.size() >= 3) cmp(q.pop_front(), got);
  end
  // hang guard, well above the roughly 1180 cycles of the whole run
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (12) @(posedge clock_i);
    go <= 1'b1;
    repeat (12) @(posedge clock_i);
    $display("disabled outputs test done");
    // a disable pulse before each config brings all halving flops into phase
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      rst <= 1'b1;
      repeat (4) @(posedge clock_i);
      drv <= {1'b1, seed[9:0] | seed[19:10]};
      dv  <= seed[23:20];
      ch  <= i[0];
      src <= i[1];
      repeat (8) @(posedge clock_i);
      rst <= 1'b0;
      repeat (80) @(posedge clock_i);
      $display("config %0d done", i);
    end
    // every pin falls to its pull level: stale notes are dropped and checking restarts
    go  <= 1'b0;
    drv <= 11'h000;
    @(negedge clock_i);
    q.delete();
    repeat (6) @(posedge clock_i);
    go <= 1'b1;
    repeat (40) @(posedge clock_i);
    $display("unconnected defaults test done");
    close_out();
  end
endmodule
bind csdf_top csdf_top_assertions csdf_top_assertions_inst (.*);
